// ### common/input_filter_pkg.sv
// Constants, register map and field layout of the input noise filter block
package input_filter_pkg;
    // Structure
    localparam int AXES = 4;
    localparam int SIGS_PER_AXIS = 10;
    localparam int GROUPS = 5;
    // Timing: base integration step derived from the clock rate
    localparam int CLOCK_MHZ = 125;
    localparam int CODE0_DELAY_NS = 2000;
    localparam int CODE1_DELAY_NS = 256000;
    localparam int INTEGRATE_STEPS = 8;
    localparam int BASE_CYCLES = CODE0_DELAY_NS * CLOCK_MHZ / 1000 / INTEGRATE_STEPS;
    localparam int SLOW_CYCLES = CODE1_DELAY_NS * CLOCK_MHZ / 1000 / INTEGRATE_STEPS;
    localparam int DIV_WIDTH = 13;
    localparam logic [4:0] BASE_LAST = 5'(BASE_CYCLES - 1);
    localparam logic [11:0] SLOW_LAST = 12'(SLOW_CYCLES - 1);
    localparam logic [3:0] INTEG_FULL = 4'(INTEGRATE_STEPS);
    // Register byte offsets on the bus
    localparam logic [5:0] OFS_MODE_LOW = 6'h00;
    localparam logic [5:0] OFS_MODE_HIGH = 6'h04;
    localparam logic [5:0] OFS_COMMAND = 6'h08;
    localparam logic [5:0] OFS_AXIS_MODE = 6'h10;
    localparam logic [5:0] OFS_AXIS_STATE = 6'h20;
    localparam logic [5:0] OFS_CHIP_STATE = 6'h30;
    // Fields of the mode data low word and the command word
    localparam int CONST_MSB = 15;
    localparam int CONST_LSB = 13;
    localparam int GROUP_LSB = 8;
    localparam int AXIS_SEL_LSB = 8;
    localparam logic [7:0] CMD_EXT_MODE = 8'h60;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    // Group enable bit indices
    localparam int GROUP_BASIC = 0;
    localparam int GROUP_IN2 = 1;
    localparam int GROUP_SERVO = 2;
    localparam int GROUP_EXT = 3;
    localparam int GROUP_IN3 = 4;
    // Per-axis signal indices
    localparam int SIG_PLUS_LIMIT = 0;
    localparam int SIG_MINUS_LIMIT = 1;
    localparam int SIG_IN0 = 2;
    localparam int SIG_IN1 = 3;
    localparam int SIG_IN2 = 4;
    localparam int SIG_IN3 = 5;
    localparam int SIG_SETTLED = 6;
    localparam int SIG_FAULT = 7;
    localparam int SIG_EXT_PLUS = 8;
    localparam int SIG_EXT_MINUS = 9;
    localparam int GROUP_OF_SIG [SIGS_PER_AXIS] = '{GROUP_BASIC, GROUP_BASIC, GROUP_BASIC,
        GROUP_BASIC, GROUP_IN2, GROUP_IN3, GROUP_SERVO, GROUP_SERVO, GROUP_EXT, GROUP_EXT};
endpackage

// ### hdl/input_noise_filter.sv
// Top of the per-axis input noise filter block with its Avalon-MM register slave
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Every external input passes an integrating filter, same set on all four axes.
// - Mode word bits 15..13 select one of eight time constants.
// - Mode word bits 12..8 pick filtered or pass-through per signal group.
// - Reset clears all mode settings so every input passes unfiltered.
// - Delay is 2us for code 0, 256us for code 1, doubling to 16.384ms.
// - Rejected noise reaches 1.75us for code 0, doubling from 224us to 14.336ms.
// - A group bit of 1 filters that group; 0 passes it straight through.
// - Bit 8 covers stop, limits, inputs 0 and 1; bit 9 covers input 2.
// - Bit 10 servo inputs, bit 11 external drive and pulser, bit 12 input 3.
// - Emergency stop and pulser filters follow X axis bits 8 and 11 only.
module input_noise_filter
    import input_filter_pkg::*;
(
    input wire logic clock, // System clock, 125 MHz
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic [5:0] address, // Avalon byte address
    input wire logic read, // Avalon read request
    input wire logic write, // Avalon write request
    input wire logic [31:0] writedata, // Avalon write data
    input wire logic [3:0] byteenable, // Avalon byte lanes
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon stall
    input wire logic emergency_stop_input, // Chip-wide stop, raw
    input wire logic ext_pulser_input, // Chip-wide pulser, raw
    input wire logic [3:0] plus_limit_input, // Per axis, raw
    input wire logic [3:0] minus_limit_input, // Per axis, raw
    input wire logic [3:0] general_input_zero, // Per axis, raw
    input wire logic [3:0] general_input_one, // Per axis, raw
    input wire logic [3:0] general_input_two, // Per axis, raw
    input wire logic [3:0] general_input_three, // Per axis, raw
    input wire logic [3:0] servo_settled_input, // Per axis, raw
    input wire logic [3:0] servo_fault_input, // Per axis, raw
    input wire logic [3:0] ext_drive_plus_input, // Per axis, raw
    input wire logic [3:0] ext_drive_minus_input, // Per axis, raw
    output logic emergency_stop_filtered, // Filtered stop
    output logic ext_pulser_filtered, // Filtered pulser
    output logic [3:0] plus_limit_filtered, // Filtered per axis
    output logic [3:0] minus_limit_filtered, // Filtered per axis
    output logic [3:0] general_zero_filtered, // Filtered per axis
    output logic [3:0] general_one_filtered, // Filtered per axis
    output logic [3:0] general_two_filtered, // Filtered per axis
    output logic [3:0] general_three_filtered, // Filtered per axis
    output logic [3:0] servo_settled_filtered, // Filtered per axis
    output logic [3:0] servo_fault_filtered, // Filtered per axis
    output logic [3:0] ext_plus_filtered, // Filtered per axis
    output logic [3:0] ext_minus_filtered // Filtered per axis
);
    typedef struct packed
    {
        logic waitrequest;
        logic [31:0] readdata;
        logic [15:0] mode_low;
        logic [15:0] mode_high;
        logic [AXES-1:0][15:0] axis_mode;
        logic [4:0] prescale;
        logic [11:0] slow_prescale;
        logic [DIV_WIDTH-1:0] divider;
        logic [7:0] tick;
    } top_state_type;

    top_state_type state;
    top_state_type next_state;
    logic [AXES-1:0][SIGS_PER_AXIS-1:0] raw;
    logic [AXES-1:0][SIGS_PER_AXIS-1:0] filt;
    logic [AXES-1:0] axis_tick;
    logic accept;
    logic [15:0] merged_low;
    logic [15:0] merged_high;

    // A request is served at the edge where waitrequest is sampled low
    assign accept = (read || write) && !state.waitrequest;

    // Byte-lane merge of the two mode staging words
    always_comb
    begin
        merged_low = state.mode_low;
        merged_high = state.mode_high;
        if (byteenable[0])
        begin
            merged_low[7:0] = writedata[7:0];
            merged_high[7:0] = writedata[7:0];
        end
        if (byteenable[1])
        begin
            merged_low[15:8] = writedata[15:8];
            merged_high[15:8] = writedata[15:8];
        end
    end

    // Bus slave, command decode and the shared time-constant tick generator
    always_comb
    begin
        next_state = state;
        // One wait cycle, then one answer cycle; read data prepared while waiting
        next_state.waitrequest = !((read || write) && state.waitrequest);
        if ((read || write) && state.waitrequest)
        begin
            next_state.readdata = 32'h0;
            if (read)
            begin
                case (address)
                    OFS_MODE_LOW: next_state.readdata = {16'h0, state.mode_low};
                    OFS_MODE_HIGH: next_state.readdata = {16'h0, state.mode_high};
                    OFS_CHIP_STATE:
                        next_state.readdata = {30'h0, ext_pulser_filtered,
                            emergency_stop_filtered};
                    default:
                    begin
                        for (int a = 0; a < AXES; a++)
                        begin
                            if (address == OFS_AXIS_MODE + 6'(4 * a))
                                next_state.readdata = {16'h0, state.axis_mode[a]};
                            if (address == OFS_AXIS_STATE + 6'(4 * a))
                                next_state.readdata = {22'h0, filt[a]};
                        end
                    end
                endcase
            end
        end
        if (accept && write)
        begin
            if (address == OFS_MODE_LOW)
                next_state.mode_low = merged_low;
            if (address == OFS_MODE_HIGH)
                next_state.mode_high = merged_high;
            // Only a full 16-bit command write with code 60h loads the axes
            if (address == OFS_COMMAND && byteenable[1:0] == 2'b11
                && writedata[7:0] == CMD_EXT_MODE)
            begin
                for (int a = 0; a < AXES; a++)
                begin
                    if (writedata[AXIS_SEL_LSB + a])
                        next_state.axis_mode[a] = state.mode_low;
                end
            end
        end
        // Code 0 step: 1/8 of its delay, rounded down to whole cycles
        next_state.tick = 8'h0;
        if (state.prescale == BASE_LAST)
        begin
            next_state.prescale = 5'h0;
            next_state.tick[0] = 1'b1;
        end
        else
        begin
            next_state.prescale = state.prescale + 5'h1;
        end
        // Slower codes share an exact step of 1/8 of the code 1 delay, so seven
        // steps keep the full rejection width; code k multiplies it by 2^(k-1)
        if (state.slow_prescale == SLOW_LAST)
        begin
            next_state.slow_prescale = 12'h0;
            next_state.divider = state.divider + DIV_WIDTH'(1);
            for (int k = 1; k < 8; k++)
            begin
                if ((state.divider & DIV_WIDTH'((1 << (k - 1)) - 1))
                    == DIV_WIDTH'((1 << (k - 1)) - 1))
                    next_state.tick[k] = 1'b1;
            end
        end
        else
        begin
            next_state.slow_prescale = state.slow_prescale + 12'h1;
        end
    end

    // All settings clear at reset, so every filter starts in bypass
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= '0;
            state.waitrequest <= 1'b1;
            state.mode_low <= MODE_RESET;
            state.mode_high <= MODE_RESET;
            state.axis_mode <= {AXES{MODE_RESET}};
        end
        else
        begin
            state <= next_state;
        end
    end

    assign waitrequest = state.waitrequest;
    assign readdata = state.readdata;

    // Per axis: pick the selected tick and build the signal vectors
    for (genvar a = 0; a < AXES; a++)
    begin : g_axis
        assign axis_tick[a] = state.tick[state.axis_mode[a][CONST_MSB:CONST_LSB]];
        assign raw[a] = {ext_drive_minus_input[a], ext_drive_plus_input[a],
            servo_fault_input[a], servo_settled_input[a], general_input_three[a],
            general_input_two[a], general_input_one[a], general_input_zero[a],
            minus_limit_input[a], plus_limit_input[a]};
        assign plus_limit_filtered[a] = filt[a][SIG_PLUS_LIMIT];
        assign minus_limit_filtered[a] = filt[a][SIG_MINUS_LIMIT];
        assign general_zero_filtered[a] = filt[a][SIG_IN0];
        assign general_one_filtered[a] = filt[a][SIG_IN1];
        assign general_two_filtered[a] = filt[a][SIG_IN2];
        assign general_three_filtered[a] = filt[a][SIG_IN3];
        assign servo_settled_filtered[a] = filt[a][SIG_SETTLED];
        assign servo_fault_filtered[a] = filt[a][SIG_FAULT];
        assign ext_plus_filtered[a] = filt[a][SIG_EXT_PLUS];
        assign ext_minus_filtered[a] = filt[a][SIG_EXT_MINUS];
        // One identical cell per input; group bit chosen by the signal's group
        for (genvar s = 0; s < SIGS_PER_AXIS; s++)
        begin : g_sig
            integrating_filter u_cell
            (
                .clock(clock),
                .rst_b(rst_b),
                .sample(raw[a][s]),
                .enable(state.axis_mode[a][GROUP_LSB + GROUP_OF_SIG[s]]),
                .tick(axis_tick[a]),
                .filtered(filt[a][s])
            );
        end
    end

    // Chip-wide inputs take their enables and time constant from the X axis only
    integrating_filter u_stop_cell
    (
        .clock(clock),
        .rst_b(rst_b),
        .sample(emergency_stop_input),
        .enable(state.axis_mode[0][GROUP_LSB + GROUP_BASIC]),
        .tick(axis_tick[0]),
        .filtered(emergency_stop_filtered)
    );

    integrating_filter u_pulser_cell
    (
        .clock(clock),
        .rst_b(rst_b),
        .sample(ext_pulser_input),
        .enable(state.axis_mode[0][GROUP_LSB + GROUP_EXT]),
        .tick(axis_tick[0]),
        .filtered(ext_pulser_filtered)
    );

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // Settings are zero when reset is released
    a_reset_clears: assert property ($rose(rst_b) |-> state.axis_mode == '0)
        else $error("axis modes not cleared by reset");

    // Base step comes right after the prescaler wraps and repeats after 31 cycles
    a_base_period: assert property (state.tick[0]
        |-> state.prescale == 5'h0 ##31 state.tick[0])
        else $error("base tick period wrong");

    // Code 2 steps only together with code 1
    a_tick_nested: assert property (state.tick[2] |-> state.tick[1])
        else $error("code 2 tick without code 1 tick");

    // Command 60h with bit 8 set loads the staged word into the X axis
    a_load_axis: assert property ((accept && write && address == OFS_COMMAND
        && byteenable[1:0] == 2'b11 && writedata[7:0] == CMD_EXT_MODE
        && writedata[AXIS_SEL_LSB]) |=> state.axis_mode[0] == $past(state.mode_low))
        else $error("axis mode not loaded by command");

    // Other command codes leave the axis settings alone
    a_other_cmd: assert property ((accept && write && address == OFS_COMMAND
        && writedata[7:0] != CMD_EXT_MODE) |=> $stable(state.axis_mode))
        else $error("axis mode changed by foreign command");

    // Bypassed servo fault line of axis 1 follows its input one cycle later
    a_servo_bypass: assert property (!state.axis_mode[1][GROUP_LSB + GROUP_SERVO]
        |=> servo_fault_filtered[1] == $past(servo_fault_input[1]))
        else $error("servo fault not passed through");

    // Pulser bypass depends only on the X axis bit 11
    a_pulser_bypass: assert property (!state.axis_mode[0][GROUP_LSB + GROUP_EXT]
        |=> ext_pulser_filtered == $past(ext_pulser_input))
        else $error("pulser not passed through");

    // Enabled stop filter holds a high output while no step comes
    a_stop_glitch: assert property ((state.axis_mode[0][GROUP_LSB + GROUP_BASIC]
        && emergency_stop_filtered && !axis_tick[0]) |=> emergency_stop_filtered)
        else $error("stop filter output moved without a step");

    // Every request is answered after exactly one wait cycle
    a_bus_answer: assert property (((read || write) && state.waitrequest)
        |=> !state.waitrequest ##1 state.waitrequest)
        else $error("bus answer timing wrong");

    c_load_cmd: cover property (accept && write && address == OFS_COMMAND
        && writedata[7:0] == CMD_EXT_MODE);
    c_stop_filtered: cover property (state.axis_mode[0][GROUP_LSB + GROUP_BASIC]
        && $rose(emergency_stop_filtered));
    c_slow_tick: cover property (state.tick[7]);
    c_read_state: cover property (accept && read && address == OFS_AXIS_STATE);
endmodule
`default_nettype wire

// ### hdl/integrating_filter.sv
// One integrating noise filter cell with pass-through bypass
`timescale 1ns/1ns
`default_nettype none
module integrating_filter
    import input_filter_pkg::*;
(
    input wire logic clock, // System clock
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic sample, // Raw input level
    input wire logic enable, // Filtering on when high
    input wire logic tick, // Integration step strobe
    output logic filtered // Filtered level
);
    typedef struct packed
    {
        logic [3:0] count;
        logic out;
    } cell_state_type;

    cell_state_type state;
    cell_state_type next_state;

    // Saturating up/down integrator; output moves only at full or empty
    always_comb
    begin
        next_state = state;
        if (!enable)
        begin
            // Bypass keeps the counter tracking, so enabling causes no glitch
            next_state.out = sample;
            next_state.count = sample ? INTEG_FULL : 4'h0;
        end
        else if (tick)
        begin
            if (sample && state.count != INTEG_FULL)
                next_state.count = state.count + 4'h1;
            else if (!sample && state.count != 4'h0)
                next_state.count = state.count - 4'h1;
            if (next_state.count == INTEG_FULL)
                next_state.out = 1'b1;
            else if (next_state.count == 4'h0)
                next_state.out = 1'b0;
        end
    end

    // Reset leaves the cell in bypass-low
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            state <= '0;
        else
            state <= next_state;
    end

    assign filtered = state.out;

    // Output only changes at a saturated count while filtering
    a_change_at_limit: assert property (@(posedge clock) disable iff (!rst_b)
        ($changed(state.out) && $past(enable)) |->
            (state.count == INTEG_FULL || state.count == 4'h0))
        else $error("filter output changed before saturation");

    // Without a tick an enabled filter holds its output
    a_hold_no_tick: assert property (@(posedge clock) disable iff (!rst_b)
        (enable && !tick) |=> $stable(state.out))
        else $error("filter output moved without a tick");
endmodule
`default_nettype wire

// ### verif/filter_partner.sv
// Model of the switches, sensors, servo drivers and pulser feeding the filter block
`timescale 1ns/1ns
`default_nettype none
module filter_partner
(
    input wire logic clock, // System clock
    output logic stop_line, // Emergency stop level
    output logic pulser_line, // Pulser level
    output logic [39:0] axis_lines // Ten signals of four axes, signal-major
);
    logic [41:0] level;

    // Lines move just after a rising edge, so the block sees a synchronised source
    task automatic drive(input logic [41:0] v);
        @(posedge clock);
        level <= v;
    endtask

    // Inactive sensors rest high
    initial level = '1;
    assign {stop_line, pulser_line, axis_lines} = level;
endmodule
`default_nettype wire

// ### verif/test_input_noise_filter.sv
// Self-checking bench of the input noise filter block
`timescale 1ns/1ns
`default_nettype none
module test_input_noise_filter
    import input_filter_pkg::*;
;
    logic clock = 1'b0;
    logic rst_b;
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest;
    logic stop_line;
    logic pulser_line;
    logic [39:0] lines;
    logic [41:0] obs;
    logic [15:0] mode [AXES] = '{default: 16'h0000};
    int err_count = 0;
    int checks = 0;

    // One half period of 4 ns gives 125 MHz
    always #4 clock = ~clock;

    filter_partner u_partner (.clock(clock), .stop_line(stop_line), .pulser_line(pulser_line),
        .axis_lines(lines));

    input_noise_filter u_dut (.clock(clock), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .emergency_stop_input(stop_line),
        .ext_pulser_input(pulser_line), .plus_limit_input(lines[3:0]),
        .minus_limit_input(lines[7:4]), .general_input_zero(lines[11:8]),
        .general_input_one(lines[15:12]), .general_input_two(lines[19:16]),
        .general_input_three(lines[23:20]), .servo_settled_input(lines[27:24]),
        .servo_fault_input(lines[31:28]), .ext_drive_plus_input(lines[35:32]),
        .ext_drive_minus_input(lines[39:36]), .emergency_stop_filtered(obs[41]),
        .ext_pulser_filtered(obs[40]), .plus_limit_filtered(obs[3:0]),
        .minus_limit_filtered(obs[7:4]), .general_zero_filtered(obs[11:8]),
        .general_one_filtered(obs[15:12]), .general_two_filtered(obs[19:16]),
        .general_three_filtered(obs[23:20]), .servo_settled_filtered(obs[27:24]),
        .servo_fault_filtered(obs[31:28]), .ext_plus_filtered(obs[35:32]),
        .ext_minus_filtered(obs[39:36]));

    task automatic end_sim();
        $display("err_count=%0d checks=%0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_vec(input string what, input logic [41:0] exp, input logic [41:0] got);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Avalon cycle: request held until waitrequest is sampled low, data taken at that edge
    task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        read <= rd;
        write <= ~rd;
        writedata <= d;
        byteenable <= be;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        if (n >= 50)
            check_word("bus answer", 32'h0, 32'h1);
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic check_reg(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b1, a, 32'h0, 4'hf, q);
        check_word("register read", exp, q);
    endtask

    // Stage a low word, then issue the extension command to the chosen axes
    task automatic set_mode(input logic [3:0] axes, input logic [15:0] m);
        logic [31:0] q;
        bus(1'b0, OFS_MODE_LOW, {16'h0, m}, 4'h3, q);
        bus(1'b0, OFS_MODE_HIGH, 32'h0, 4'h3, q);
        bus(1'b0, OFS_COMMAND, {20'h0, axes, CMD_EXT_MODE}, 4'h3, q);
        for (int a = 0; a < AXES; a++)
            if (axes[a])
                mode[a] = m;
    endtask

    // Which observed lines should sit behind a filter for the current modes
    function automatic logic [41:0] filt_mask();
        logic [41:0] k;
        k = '0;
        for (int s = 0; s < SIGS_PER_AXIS; s++)
            for (int a = 0; a < AXES; a++)
                k[4*s+a] = mode[a][GROUP_LSB+GROUP_OF_SIG[s]];
        k[41] = mode[0][GROUP_LSB+GROUP_BASIC];
        k[40] = mode[0][GROUP_LSB+GROUP_EXT];
        return k;
    endfunction

    // Reset state: everything bypassed, unmapped and command places read zero
    task automatic t_reset();
        for (int a = 0; a < AXES; a++)
            check_reg(OFS_AXIS_MODE + 6'(4*a), {16'h0, MODE_RESET});
        check_reg(6'h3c, 32'h0);
        check_reg(OFS_COMMAND, 32'h0);
        u_partner.drive('0);
        repeat (3) @(posedge clock);
        check_vec("bypass low", '0, obs);
        u_partner.drive('1);
        repeat (3) @(posedge clock);
        check_vec("bypass high", '1, obs);
        check_reg(OFS_CHIP_STATE, 32'h00000003);
        check_reg(OFS_AXIS_STATE, 32'h000003ff);
    endtask

    // Reset in mid-run drops loaded settings back to pass-through
    task automatic t_rerun();
        set_mode(4'hf, 16'h4900);
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        mode = '{default: 16'h0000};
        for (int a = 0; a < AXES; a++)
            check_reg(OFS_AXIS_MODE + 6'(4*a), {16'h0, MODE_RESET});
        check_vec("bypass after reset", '1, obs);
    endtask

    // Loading, per-axis targeting and refused commands
    task automatic t_load();
        logic [31:0] q;
        set_mode(4'h3, 16'h4900);
        set_mode(4'hc, 16'h8900);
        for (int a = 0; a < AXES; a++)
            check_reg(OFS_AXIS_MODE + 6'(4*a), {16'h0, mode[a]});
        bus(1'b0, OFS_MODE_LOW, 32'h0, 4'h3, q);
        bus(1'b0, OFS_COMMAND, 32'h0f60, 4'h1, q);
        bus(1'b0, OFS_COMMAND, 32'h0f61, 4'h3, q);
        check_reg(OFS_AXIS_MODE, 32'h4900);
        check_reg(OFS_AXIS_MODE + 6'h0c, 32'h8900);
        set_mode(4'hf, 16'h0000);
    endtask

    // A short low glitch is swallowed by filtered lines and passed by bypassed ones
    task automatic t_glitch();
        u_partner.drive('0);
        repeat (10) @(posedge clock);
        check_vec("glitch lines", filt_mask(), obs);
        u_partner.drive('1);
        repeat (40) @(posedge clock);
    endtask

    // Each group bit alone, on all axes and then with the X axis left bypassed
    task automatic t_groups();
        for (int p = 0; p < 2; p++)
            for (int g = 0; g < GROUPS; g++)
            begin
                set_mode(4'hf, 16'h0000);
                set_mode(p ? 4'he : 4'hf, 16'(1 << (GROUP_LSB + g)));
                t_glitch();
            end
        set_mode(4'hf, 16'h0000);
    endtask

    // A lasting drop shows after the delay of the code, not before the rejection width
    task automatic t_delay(input logic [2:0] code, input int rej_ns, input int del_ns,
        input int slack);
        set_mode(4'h1, {code, 5'h01, 8'h00});
        u_partner.drive('0);
        repeat (rej_ns * CLOCK_MHZ / 1000 - 20) @(posedge clock);
        check_vec("held level", 42'h20000000001, obs & 42'h20000000001);
        repeat (del_ns * CLOCK_MHZ / 1000 - rej_ns * CLOCK_MHZ / 1000 + 20 + slack)
            @(posedge clock);
        check_vec("settled level", '0, obs);
        set_mode(4'hf, 16'h0000);
        u_partner.drive('1);
        repeat (3) @(posedge clock);
    endtask

    initial
    begin
        rst_b <= 1'b0;
        address <= 6'h00;
        read <= 1'b0;
        write <= 1'b0;
        writedata <= 32'h00000000;
        byteenable <= 4'h3;
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        t_reset();
        t_load();
        t_rerun();
        t_groups();
        t_delay(3'd0, 1750, 2000, 40);
        t_delay(3'd1, 224000, 256000, 300);
        end_sim();
    end

    // Watchdog sized to the slowest delay case with a generous margin
    initial
    begin
        #(8 * 60000);
        err_count++;
        end_sim();
    end
endmodule
`default_nettype wire
